// ---- hw/rpf_pkg.sv ----
// Notes on behaviour
// [R01] Host writes configuration only while the radio is idle or powered down.
// [R02] Transmit FIFO holds three payloads of up to 32 bytes each.
// [R03] Receive FIFO holds three payloads of up to 32 bytes each.
// [R04] As receiver, transmit FIFO holds acknowledge payloads for three peers at once.
// [R05] Entries aimed at one pipe leave in first-in first-out order.
// [R06] As receiver, FIFO blocks when all pending pipes lost; host may flush.
// [R07] As transmitter, at most three payloads are queued.
// [R08] As receiver, receive FIFO accepts payloads from three different peers.
// [R09] Transmit FIFO written only by the two transmit commands or acknowledge command.
// [R10] Receive FIFO readable by the read-payload command in either role.
// [R11] Retransmit limit event leaves the head transmit payload in place.
// [R12] Full and empty of both FIFOs are readable status flags.
// [R13] Interrupt output is active low.
// [R14] Interrupt asserts when sent, received or retransmit-limit flag sets.
// [R15] Writing one clears a flag; interrupt releases when no unmasked flag remains.
// [R16] A high mask bit keeps its flag off the interrupt output.
// [R17] After reset all three interrupt sources are unmasked.
// [R18] Pipe number field updates as the interrupt output falls.
// [R19] Data bytes go low byte first, each byte most significant bit first.
// [R20] Every command begins with chip select falling.
// [R21] Payload read starts at byte 0; payload removed once read.
// [R22] Command 1110 0001 empties the transmit FIFO, no data bytes.
// [R23] Acknowledge write carries pipe 000 to 101 in its low bits.
// [R24] Payload writes to a full FIFO are ignored.
// [R25] Flag clear acts at end of write; a new event sets it again.
package rpf_pkg;
    localparam int PAYLOAD_BYTES = 32;
    localparam int FIFO_DEPTH = 3;
    localparam logic [7:0] CMD_RD_RX = 8'h61;
    localparam logic [7:0] CMD_WR_TX = 8'ha0;
    localparam logic [7:0] CMD_WR_NOACK = 8'hb0;
    localparam logic [4:0] CMD_WR_ACK_TOP = 5'h15;
    localparam logic [7:0] CMD_FLUSH_TX = 8'he1;
    localparam logic [7:0] CMD_FLUSH_RX = 8'he2;
    localparam logic [2:0] CMD_RREG_TOP = 3'h0;
    localparam logic [2:0] CMD_WREG_TOP = 3'h1;
    localparam logic [4:0] ADDR_CONFIG = 5'h00;
    localparam logic [4:0] ADDR_STATUS = 5'h07;
    localparam logic [4:0] ADDR_FIFO_STATUS = 5'h17;
    localparam logic [7:0] CONFIG_RESET = 8'h08;
    localparam int CFG_MASK_LSB = 4;
    localparam int CFG_PRIM_RX = 0;
    localparam int ST_FLAG_LSB = 4;
    localparam logic [2:0] PIPE_NONE = 3'h7;
    localparam logic [2:0] PIPE_LAST = 3'h5;
    localparam logic [1:0] RX_FULL_CNT = 2'h3;

    typedef struct packed {
        logic data_received_flag;
        logic data_sent_flag;
        logic retransmit_limit_flag;
    } rpf_flags_t;

    typedef struct packed {
        logic first;
        logic [7:0] data;
    } rpf_evt_t;

    typedef struct packed {
        logic [5:0] len;
        logic [2:0] pipe;
        logic noack;
    } rpf_txent_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] config_b;
        logic [7:0] fifo;
        logic [7:0] rx0;
    } rpf_pub_t;

    typedef enum logic [4:0] {
        CS_IDLE = 5'h01,
        CS_TXWR = 5'h02,
        CS_RXRD = 5'h04,
        CS_REGWR = 5'h08,
        CS_DROP = 5'h10
    } rpf_state_t;
endpackage

// ---- hw/rpf_top.sv ----
`timescale 1ns/100ps
module rpf_top
    import rpf_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic link_sck,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso_q,
    output logic spi_miso_oe_q,
    output logic irq_n_q,
    output logic [2:0] pipe_no_q,
    output logic [7:0] config_q,
    output rpf_flags_t flags_q,
    output logic [7:0] fifo_status_q,
    input wire logic [5:0] pipe_lost,
    input wire logic eng_tx_done,
    input wire logic eng_retransmit_limit_flag,
    input wire logic [4:0] eng_tx_raddr,
    output logic [7:0] tx_rdata_q,
    output logic tx_head_valid_q,
    output rpf_txent_t tx_head_q,
    input wire logic eng_rx_we,
    input wire logic [4:0] eng_rx_waddr,
    input wire logic [7:0] eng_rx_wdata,
    input wire logic eng_rx_commit,
    input wire logic [2:0] eng_rx_pipe
);
    // ==========================================================
    // reset and crossings
    logic rst_s1_q, rst_n_q;
    logic cs_s1_q, cs_s2_q, cs_s3_q, cs_s4_q;
    logic ev_s1_q, ev_s2_q, ev_s3_q, adv_s1_q, adv_s2_q, adv_s3_q;
    logic evt_tgl_q, adv_tgl_q;
    rpf_evt_t evt_q;
    logic frame_end, evt_now, adv_now;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            {cs_s1_q, cs_s2_q, cs_s3_q, cs_s4_q} <= 4'hf;
            {ev_s1_q, ev_s2_q, ev_s3_q} <= 3'h0;
            {adv_s1_q, adv_s2_q, adv_s3_q} <= 3'h0;
            spi_miso_oe_q <= 1'b0;
        end
        else
        begin
            {cs_s1_q, cs_s2_q, cs_s3_q, cs_s4_q} <= {spi_cs_n, cs_s1_q, cs_s2_q, cs_s3_q};
            {ev_s1_q, ev_s2_q, ev_s3_q} <= {evt_tgl_q, ev_s1_q, ev_s2_q};
            {adv_s1_q, adv_s2_q, adv_s3_q} <= {adv_tgl_q, adv_s1_q, adv_s2_q};
            spi_miso_oe_q <= !cs_s2_q;
        end
    end

    // frame end is taken one stage late so the last byte event lands first
    assign frame_end = cs_s3_q && !cs_s4_q;
    assign evt_now = ev_s2_q ^ ev_s3_q;
    assign adv_now = adv_s2_q ^ adv_s3_q;

    // ==========================================================
    // link side, clocked by the serial clock
    logic [2:0] bit_q;
    logic first_q, later_q;
    logic [6:0] in_sh_q, out_sh_q;
    logic [7:0] cmd_q, next_byte;
    rpf_pub_t pub_q;
    logic [7:0] rd_word_q;

    function automatic logic [7:0] first_reply(logic [7:0] cmd, rpf_pub_t p);
        logic [7:0] r;
        r = 8'h00;
        if (cmd == CMD_RD_RX)
            r = p.rx0;
        else if (cmd[7:5] == CMD_RREG_TOP)
        begin
            case (cmd[4:0])
                ADDR_CONFIG: r = p.config_b;
                ADDR_STATUS: r = p.status;
                ADDR_FIFO_STATUS: r = p.fifo;
                default: r = 8'h00;
            endcase
        end
        return r;
    endfunction

    // [R20] chip select high clears the frame
    always_ff @(posedge link_sck or posedge spi_cs_n)
    begin
        if (spi_cs_n)
        begin
            bit_q <= 3'h0;
            first_q <= 1'b1;
            later_q <= 1'b0;
            in_sh_q <= 7'h00;
            cmd_q <= 8'h00;
        end
        else
        begin
            bit_q <= bit_q + 3'h1;
            in_sh_q <= {in_sh_q[5:0], spi_mosi};
            if (bit_q == 3'h7)
            begin
                first_q <= 1'b0;
                later_q <= !first_q;
                if (first_q)
                    cmd_q <= {in_sh_q, spi_mosi};
            end
        end
    end

    // toggles survive chip select so no false event is made
    always_ff @(posedge link_sck or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            evt_q <= '0;
            evt_tgl_q <= 1'b0;
            adv_tgl_q <= 1'b0;
        end
        else
        begin
            if (bit_q == 3'h7 && !spi_cs_n)
            begin
                evt_q <= '{first: first_q, data: {in_sh_q, spi_mosi}};
                evt_tgl_q <= !evt_tgl_q;
            end
            // mid-byte request leaves half a byte for the next read word
            if (bit_q == 3'h3 && !first_q && !spi_cs_n)
                adv_tgl_q <= !adv_tgl_q;
        end
    end

    assign next_byte = !later_q ? first_reply(cmd_q, pub_q) : (cmd_q == CMD_RD_RX ? rd_word_q : 8'h00);

    // [R19] each byte leaves most significant bit first
    always_ff @(negedge link_sck or posedge spi_cs_n)
    begin
        if (spi_cs_n)
        begin
            spi_miso_q <= 1'b0;
            out_sh_q <= 7'h00;
        end
        else if (bit_q == 3'h0)
        begin
            spi_miso_q <= next_byte[7];
            out_sh_q <= next_byte[6:0];
        end
        else if (bit_q == 3'h1 && first_q)
        begin
            spi_miso_q <= pub_q.status[6];
            out_sh_q <= {pub_q.status[5:0], 1'b0};
        end
        else
        begin
            spi_miso_q <= out_sh_q[6];
            out_sh_q <= {out_sh_q[5:0], 1'b0};
        end
    end

    // ==========================================================
    // command handling
    rpf_state_t st_q;
    logic [7:0] tx_mem [0:FIFO_DEPTH*PAYLOAD_BYTES-1];
    logic [7:0] rx_mem [0:FIFO_DEPTH*PAYLOAD_BYTES-1];
    rpf_txent_t tx_ent_q [FIFO_DEPTH];
    logic [1:0] tx_age_q [FIFO_DEPTH];
    logic [1:0] age_d [FIFO_DEPTH];
    logic [2:0] tx_valid_q, tv_d;
    logic [1:0] wr_slot_q, hd_slot_q, free_slot, pick_slot;
    logic [5:0] wr_cnt_q, rd_cnt_q;
    logic [4:0] rd_idx_q, reg_addr_q;
    logic [2:0] rx_pipe_q [FIFO_DEPTH];
    logic [1:0] rx_wp_q, rx_rp_q, rx_cnt_q;
    logic primary_receiver_role, tx_full, rx_full, flush_tx, flush_rx, commit_tx, pop_rx, push_rx, has_free, pick_ok;
    logic is_txcmd;
    rpf_flags_t flag_set, flag_clr, mask;
    logic [2:0] pipe_src;

    function automatic logic [1:0] wrap_inc(logic [1:0] v);
        return (v == 2'(FIFO_DEPTH - 1)) ? 2'h0 : v + 2'h1;
    endfunction

    assign primary_receiver_role = config_q[CFG_PRIM_RX];
    assign mask = config_q[CFG_MASK_LSB +: 3];
    assign tx_full = &tx_valid_q;
    assign rx_full = rx_cnt_q == RX_FULL_CNT;
    assign has_free = !tx_full;
    assign free_slot = !tx_valid_q[0] ? 2'h0 : (!tx_valid_q[1] ? 2'h1 : 2'h2);
    // [R09] only the role's own payload commands open a write
    // [R23] ack pipe above 5 refused
    assign is_txcmd = (!primary_receiver_role && (evt_q.data == CMD_WR_TX || evt_q.data == CMD_WR_NOACK))
        || (primary_receiver_role && evt_q.data[7:3] == CMD_WR_ACK_TOP && evt_q.data[2:0] <= PIPE_LAST);
    // [R22] flush acts as soon as the command byte is in
    assign flush_tx = evt_now && evt_q.first && evt_q.data == CMD_FLUSH_TX;
    assign flush_rx = evt_now && evt_q.first && evt_q.data == CMD_FLUSH_RX;
    assign commit_tx = frame_end && st_q == CS_TXWR && wr_cnt_q != 6'h00;
    // [R21] a read of at least one byte removes the head payload
    assign pop_rx = frame_end && st_q == CS_RXRD && rd_cnt_q != 6'h00 && rx_cnt_q != 2'h0;
    // [R24] engine payloads beyond three are dropped
    assign push_rx = eng_rx_commit && !rx_full;

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            st_q <= CS_IDLE;
            wr_slot_q <= 2'h0;
            wr_cnt_q <= 6'h00;
            rd_cnt_q <= 6'h00;
            rd_idx_q <= 5'h00;
            reg_addr_q <= 5'h00;
        end
        else if (frame_end)
            st_q <= CS_IDLE;
        else if (evt_now && evt_q.first)
        begin
            wr_cnt_q <= 6'h00;
            rd_cnt_q <= 6'h00;
            rd_idx_q <= 5'h00;
            reg_addr_q <= evt_q.data[4:0];
            wr_slot_q <= free_slot;
            if (evt_q.data == CMD_RD_RX)
                st_q <= CS_RXRD;
            // [R24] a write to a full transmit FIFO is swallowed
            else if (is_txcmd && has_free)
                st_q <= CS_TXWR;
            // [R01] register writes are accepted in any mode
            else if (evt_q.data[7:5] == CMD_WREG_TOP)
                st_q <= CS_REGWR;
            else
                st_q <= CS_DROP;
        end
        else
        begin
            if (evt_now && st_q == CS_TXWR && wr_cnt_q != 6'(PAYLOAD_BYTES))
                wr_cnt_q <= wr_cnt_q + 6'h01;
            if (evt_now && st_q == CS_RXRD && rd_cnt_q != 6'(PAYLOAD_BYTES))
                rd_cnt_q <= rd_cnt_q + 6'h01;
            if (adv_now && st_q == CS_RXRD)
                rd_idx_q <= rd_idx_q + 5'h01;
            if (evt_now && st_q == CS_REGWR)
                st_q <= CS_DROP;
        end
    end

    // [R02] payload bytes land from byte 0 of the slot
    always_ff @(posedge clk)
    begin
        if (evt_now && !evt_q.first && st_q == CS_TXWR && wr_cnt_q != 6'(PAYLOAD_BYTES))
            tx_mem[{wr_slot_q, wr_cnt_q[4:0]}] <= evt_q.data;
        if (eng_rx_we && !rx_full)
            rx_mem[{rx_wp_q, eng_rx_waddr}] <= eng_rx_wdata;
    end

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            rd_word_q <= 8'h00;
        // [R21] bytes after byte 0 are fetched a half byte ahead
        else if (adv_now && st_q == CS_RXRD)
            rd_word_q <= rx_mem[{rx_rp_q, 5'(rd_idx_q + 5'h01)}];
    end

    // ==========================================================
    // transmit slots
    always_comb
    begin
        pick_ok = 1'b0;
        pick_slot = 2'h0;
        // [R05] oldest entry first; [R06] lost pipes are skipped as receiver
        for (int a = 0; a < FIFO_DEPTH; a++)
            for (int s = 0; s < FIFO_DEPTH; s++)
                if (!pick_ok && tx_valid_q[s] && tx_age_q[s] == 2'(a)
                    && !(primary_receiver_role && tx_ent_q[s].pipe <= PIPE_LAST && pipe_lost[tx_ent_q[s].pipe]))
                begin
                    pick_ok = 1'b1;
                    pick_slot = 2'(s);
                end
    end

    always_comb
    begin
        tv_d = tx_valid_q;
        age_d = tx_age_q;
        if (flush_tx)
            tv_d = 3'h0;
        else
        begin
            if (eng_tx_done && tx_head_valid_q)
            begin
                tv_d[hd_slot_q] = 1'b0;
                for (int s = 0; s < FIFO_DEPTH; s++)
                    if (tx_valid_q[s] && tx_age_q[s] > tx_age_q[hd_slot_q])
                        age_d[s] = tx_age_q[s] - 2'h1;
            end
            if (commit_tx)
            begin
                age_d[wr_slot_q] = 2'($countones(tv_d));
                tv_d[wr_slot_q] = 1'b1;
            end
        end
    end

    // [R07] three slots cap the queue; [R04] each slot keeps its own pipe
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            tx_valid_q <= 3'h0;
            for (int s = 0; s < FIFO_DEPTH; s++)
            begin
                tx_age_q[s] <= 2'h0;
                tx_ent_q[s] <= '0;
            end
            hd_slot_q <= 2'h0;
            tx_head_valid_q <= 1'b0;
            tx_head_q <= '0;
            tx_rdata_q <= 8'h00;
        end
        else
        begin
            // [R11] only a completed send or a transmit flush retires the head
            tx_valid_q <= tv_d;
            tx_age_q <= age_d;
            if (commit_tx)
                tx_ent_q[wr_slot_q] <= '{len: wr_cnt_q, pipe: primary_receiver_role ? reg_addr_q[2:0] : 3'h0,
                    noack: !primary_receiver_role && reg_addr_q == CMD_WR_NOACK[4:0]};
            hd_slot_q <= pick_slot;
            tx_head_valid_q <= pick_ok && !flush_tx && !(eng_tx_done && tx_head_valid_q);
            tx_head_q <= tx_ent_q[pick_slot];
            tx_rdata_q <= tx_mem[{hd_slot_q, eng_tx_raddr}];
        end
    end

    // ==========================================================
    // receive ring
    // [R03] [R08] three entries, any pipe each
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            rx_wp_q <= 2'h0;
            rx_rp_q <= 2'h0;
            rx_cnt_q <= 2'h0;
            for (int s = 0; s < FIFO_DEPTH; s++)
                rx_pipe_q[s] <= 3'h0;
        end
        else if (flush_rx)
        begin
            rx_rp_q <= rx_wp_q;
            rx_cnt_q <= 2'h0;
        end
        else
        begin
            if (push_rx)
            begin
                rx_pipe_q[rx_wp_q] <= eng_rx_pipe;
                rx_wp_q <= wrap_inc(rx_wp_q);
            end
            // [R10] read works in either role
            if (pop_rx)
                rx_rp_q <= wrap_inc(rx_rp_q);
            rx_cnt_q <= rx_cnt_q + 2'(push_rx) - 2'(pop_rx);
        end
    end

    // ==========================================================
    // flags, interrupt, published status
    assign flag_set = '{data_received_flag: push_rx, data_sent_flag: eng_tx_done && tx_head_valid_q, retransmit_limit_flag: eng_retransmit_limit_flag};
    assign flag_clr = (evt_now && st_q == CS_REGWR && reg_addr_q == ADDR_STATUS)
        ? evt_q.data[ST_FLAG_LSB +: 3] : 3'h0;
    assign pipe_src = rx_cnt_q == 2'h0 ? PIPE_NONE : rx_pipe_q[rx_rp_q];

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            flags_q <= '0;
            // [R17] masks start cleared
            config_q <= CONFIG_RESET;
            irq_n_q <= 1'b1;
            pipe_no_q <= PIPE_NONE;
            fifo_status_q <= 8'h11;
            pub_q <= '0;
        end
        else
        begin
            // [R25] clear lands at write end, a same-cycle event wins
            flags_q <= (flags_q & ~flag_clr) | flag_set;
            if (evt_now && st_q == CS_REGWR && reg_addr_q == ADDR_CONFIG)
                config_q <= evt_q.data;
            // [R13] [R14] [R15] [R16] low while any unmasked flag stands
            irq_n_q <= ~|(flags_q & ~mask);
            // [R18] pipe field moves with the falling interrupt edge
            if (irq_n_q && |(flags_q & ~mask))
                pipe_no_q <= pipe_src;
            // [R12] full and empty of both FIFOs
            fifo_status_q <= {2'h0, tx_full, tx_valid_q == 3'h0, 2'h0, rx_full, rx_cnt_q == 2'h0};
            // words the link reads are frozen while a frame runs
            if (cs_s2_q && st_q == CS_IDLE)
                pub_q <= '{status: {1'b0, flags_q, pipe_no_q, tx_full}, config_b: config_q,
                    fifo: fifo_status_q, rx0: rx_mem[{rx_rp_q, 5'h00}]};
        end
    end

    // ==========================================================
    // checks
    a_irq_assert_gate: assert property (@(posedge clk) disable iff (!rst_n_q) // [R14]
        |(flags_q & ~mask) |=> !irq_n_q) else $error("unmasked flag did not pull interrupt low");
    a_irq_mask_hold: assert property (@(posedge clk) disable iff (!rst_n_q) // [R16]
        (flags_q & ~mask) == 3'h0 |=> irq_n_q) else $error("interrupt low with all flags masked");
    a_flag_set_wins: assert property (@(posedge clk) disable iff (!rst_n_q) // [R25]
        (flag_set.data_received_flag && flag_clr.data_received_flag) |=> flags_q.data_received_flag) else $error("clear beat a new event");
    a_flag_clear_w1c: assert property (@(posedge clk) disable iff (!rst_n_q) // [R15]
        (flag_clr.retransmit_limit_flag && !flag_set.retransmit_limit_flag) |=> !flags_q.retransmit_limit_flag) else $error("write one did not clear");
    a_maxrt_keeps_head: assert property (@(posedge clk) disable iff (!rst_n_q) // [R11]
        (eng_retransmit_limit_flag && !eng_tx_done && !flush_tx) |=> (tx_valid_q & $past(tx_valid_q)) == $past(tx_valid_q))
        else $error("retransmit limit dropped a payload");
    a_flush_empties: assert property (@(posedge clk) disable iff (!rst_n_q) // [R22]
        flush_tx |=> tx_valid_q == 3'h0 ##2 !tx_head_valid_q) else $error("flush left payloads");
    a_rx_full_ignore: assert property (@(posedge clk) disable iff (!rst_n_q) // [R24]
        (rx_full && eng_rx_commit && !pop_rx && !flush_rx) |=> rx_full && $stable(rx_wp_q))
        else $error("write into full receive FIFO");
    a_rx_read_pops: assert property (@(posedge clk) disable iff (!rst_n_q) // [R21]
        (pop_rx && !push_rx) |=> rx_cnt_q == $past(rx_cnt_q) - 2'h1) else $error("read payload not removed");
    a_pipe_on_fall: assert property (@(posedge clk) disable iff (!rst_n_q) // [R18]
        $fell(irq_n_q) |-> pipe_no_q == $past(pipe_src)) else $error("pipe field not updated on fall");
    a_mask_reset: assert property (@(posedge clk) disable iff (!rst_n_q) // [R17]
        $rose(rst_n_q) |-> config_q[CFG_MASK_LSB +: 3] == 3'h0) else $error("masks set after reset");
endmodule

// ---- bench/rpf_host.sv ----
`timescale 1ns/100ps
module rpf_host
(
    output logic link_sck,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso_q
);
    logic [7:0] tx_b [33];
    logic [7:0] rx_b [33];
    realtime low_ns = 62.5;
    initial
    begin
        link_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // ========
    // frame
    // ========
    task automatic xfer(input int n);
        spi_cs_n = 1'b0;
        #100;
        for (int i = 0; i < n; i++)
            // bytes in array order, msb first
            for (int b = 7; b >= 0; b--)
            begin
                spi_mosi = tx_b[i][b];
                #(low_ns);
                link_sck = 1'b1;
                rx_b[i][b] = spi_miso_q;
                #62.5;
                link_sck = 1'b0;
            end
        #62.5;
        spi_cs_n = 1'b1;
        // idle line must not repeat the last bit
        spi_mosi = ~spi_mosi;
        #250;
    endtask
endmodule

// ---- bench/rpf_top_tb.sv ----
`timescale 1ns/100ps
module rpf_top_tb
    import rpf_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic link_sck, spi_cs_n, spi_mosi, spi_miso_q, spi_miso_oe_q, irq_n_q, tx_head_valid_q;
    logic [2:0] pipe_no_q;
    logic [7:0] config_q, fifo_status_q, tx_rdata_q;
    rpf_flags_t flags_q;
    rpf_txent_t tx_head_q;
    logic [5:0] pipe_lost = 6'h00;
    logic eng_tx_done = 1'b0;
    logic eng_retransmit_limit_flag = 1'b0;
    logic eng_rx_we = 1'b0;
    logic eng_rx_commit = 1'b0;
    logic [4:0] eng_tx_raddr = 5'h00;
    logic [4:0] eng_rx_waddr = 5'h00;
    logic [7:0] eng_rx_wdata = 8'h00;
    logic [2:0] eng_rx_pipe = 3'h0;
    logic [7:0] lfsr_q = 8'h0f;
    logic [7:0] pay [4][32];
    logic [7:0] acmd [5] = '{8'had, 8'hae, 8'ha0, 8'haa, 8'ha9};
    int fails = 0;
    int check_count = 0;
    rpf_top u_rpf_top (.clk(clk), .resetn(resetn), .link_sck(link_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso_q(spi_miso_q), .spi_miso_oe_q(spi_miso_oe_q), .irq_n_q(irq_n_q), .pipe_no_q(pipe_no_q),
        .config_q(config_q), .flags_q(flags_q), .fifo_status_q(fifo_status_q), .pipe_lost(pipe_lost),
        .eng_tx_done(eng_tx_done), .eng_retransmit_limit_flag(eng_retransmit_limit_flag), .eng_tx_raddr(eng_tx_raddr), .tx_rdata_q(tx_rdata_q),
        .tx_head_valid_q(tx_head_valid_q), .tx_head_q(tx_head_q), .eng_rx_we(eng_rx_we),
        .eng_rx_waddr(eng_rx_waddr), .eng_rx_wdata(eng_rx_wdata), .eng_rx_commit(eng_rx_commit),
        .eng_rx_pipe(eng_rx_pipe));
    rpf_host u_rpf_host (.link_sck(link_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso_q(spi_miso_q));
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    // ========
    // helpers
    // ========
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic int plen(input int k);
        return (k == 0) ? 32 : k + 1;
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (irq_n_q !== lvl && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        if (irq_n_q !== lvl)
        begin
            fails++;
            $display("FAIL %0t interrupt wait timed out", $time);
            stop_test();
        end
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] v, input int n);
        u_rpf_host.tx_b[0] = c;
        u_rpf_host.tx_b[1] = v;
        u_rpf_host.xfer(n);
    endtask
    task automatic wpay(input logic [7:0] c, input int k);
        u_rpf_host.tx_b[0] = c;
        for (int i = 0; i < plen(k); i++)
            u_rpf_host.tx_b[i + 1] = pay[k][i];
        u_rpf_host.xfer(plen(k) + 1);
    endtask
    task automatic head_bytes(input int k);
        for (int i = 0; i < plen(k); i++)
        begin
            @(posedge clk) eng_tx_raddr <= 5'(i);
            @(posedge clk);
            @(negedge clk);
            chk(tx_rdata_q, pay[k][i]);
        end
    endtask
    task automatic strobe(input logic done);
        @(posedge clk);
        eng_tx_done <= done;
        eng_retransmit_limit_flag <= !done;
        @(posedge clk);
        eng_tx_done <= 1'b0;
        eng_retransmit_limit_flag <= 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic rxpush(input int k, input logic [2:0] p);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            eng_rx_we <= 1'b1;
            eng_rx_waddr <= 5'(i);
            eng_rx_wdata <= pay[k][i];
        end
        @(posedge clk);
        eng_rx_we <= 1'b0;
        eng_rx_commit <= 1'b1;
        eng_rx_pipe <= p;
        @(posedge clk);
        eng_rx_commit <= 1'b0;
    endtask
    // ========
    // sequence
    // ========
    initial
    begin
        for (int k = 0; k < 4; k++)
            for (int i = 0; i < 32; i++)
            begin
                lfsr_q = lfsr_next(lfsr_q);
                pay[k][i] = lfsr_q;
            end
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(negedge clk);
        chk(config_q, CONFIG_RESET);
        chk({irq_n_q, pipe_no_q, spi_miso_oe_q, 3'h0}, {1'b1, PIPE_NONE, 4'h0});
        chk(fifo_status_q, 8'h11);
        for (int k = 0; k < 4; k++)
            wpay((k == 1) ? CMD_WR_NOACK : CMD_WR_TX, k);
        chk(fifo_status_q, 8'h21);
        chk({2'b00, tx_head_q.len}, 8'h20);
        head_bytes(0);
        strobe(1'b0);
        wait_irq(1'b0);
        chk({5'h0, flags_q}, 8'h01);
        head_bytes(0);
        cmd({CMD_WREG_TOP, ADDR_STATUS}, 8'h10, 2);
        chk(u_rpf_host.rx_b[0] & 8'hf0, 8'h10);
        wait_irq(1'b1);
        strobe(1'b1);
        chk({4'h0, tx_head_q.noack, flags_q}, 8'h0a);
        head_bytes(1);
        cmd({CMD_WREG_TOP, ADDR_CONFIG}, 8'h28, 2);
        wait_irq(1'b1);
        chk({5'h0, flags_q}, 8'h02);
        cmd({CMD_WREG_TOP, ADDR_STATUS}, 8'h20, 2);
        cmd(CMD_FLUSH_TX, 8'h00, 1);
        chk({tx_head_valid_q, fifo_status_q[6:0]}, 8'h11);
        cmd({CMD_WREG_TOP, ADDR_CONFIG}, 8'h09, 2);
        for (int k = 0; k < 4; k++)
            rxpush(k, 3'(k + 3));
        @(negedge clk);
        chk({5'h0, pipe_no_q}, 8'h03);
        chk(fifo_status_q, 8'h12);
        cmd({CMD_RREG_TOP, ADDR_FIFO_STATUS}, 8'hff, 2);
        chk(u_rpf_host.rx_b[1], 8'h12);
        for (int k = 0; k < 3; k++)
        begin
            cmd(CMD_RD_RX, 8'hff, 9);
            for (int i = 0; i < 8; i++)
                chk(u_rpf_host.rx_b[i + 1], pay[k][i]);
        end
        chk(fifo_status_q, 8'h11);
        foreach (acmd[j])
        begin
            wpay(acmd[j], 1);
            chk({7'h0, fifo_status_q[5]}, {7'h0, j == 4});
        end
        chk({tx_head_valid_q, 4'h0, tx_head_q.pipe}, 8'h85);
        @(posedge clk) pipe_lost <= 6'h26;
        repeat (3) @(negedge clk);
        chk({7'h0, tx_head_valid_q}, 8'h00);
        cmd(CMD_FLUSH_TX, 8'h00, 1);
        chk(fifo_status_q, 8'h11);
        rxpush(0, 3'h1);
        repeat (2) @(negedge clk);
        chk(fifo_status_q, 8'h10);
        cmd(CMD_FLUSH_RX, 8'h00, 1);
        chk(fifo_status_q, 8'h11);
        stop_test();
    end
endmodule
